// File: design/dmd_pkg.sv
// package: encodings, phases and reset values for the data-move decoder
package dmd_pkg;
   localparam int IW = 14;
   localparam int DW = 8;
   localparam int AW = 7;
   // ---------------------------------------------
   // encoding fields
   // ---------------------------------------------
   localparam logic [3:0] LIT_TOP_VAL = 4'hC;
   localparam int LIT_TOP_LSB = 10;
   localparam logic [5:0] COPY_TOP_VAL = 6'h08;
   localparam logic [6:0] STORE_TOP_VAL = 7'h01;
   localparam logic [13:0] IDLE_MASK = 14'h3F9F;
   localparam logic [13:0] IDLE_VAL = 14'h0000;
   localparam int DEST_BIT = 7;
   // ---------------------------------------------
   // phases, operation codes and reset values
   // ---------------------------------------------
   typedef enum logic [1:0] {
      PH_Q1 = 2'b00,
      PH_Q2 = 2'b01,
      PH_Q3 = 2'b10,
      PH_Q4 = 2'b11
   } dmd_phase_type;
   typedef enum logic [2:0] {
      OP_NONE = 3'b000,
      OP_LIT = 3'b001,
      OP_COPY = 3'b010,
      OP_STORE = 3'b011,
      OP_IDLE = 3'b100
   } dmd_op_type;
   localparam logic [7:0] ACC_RST = 8'h00;
   localparam logic ZERO_RST = 1'b0;
endpackage

// File: design/dmd_dec_if.sv
// interface: decoded instruction between decoder and executor
`timescale 1ns/10ps
interface dmd_dec_if;
   dmd_pkg::dmd_op_type op;
   logic dest_reg;
   logic [7:0] lit;
   logic [6:0] addr;
   modport dec (output op, output dest_reg, output lit, output addr);
   modport exe (input op, input dest_reg, input lit, input addr);
endinterface

// File: design/dmd_decode.sv
// decoder: classifies the instruction word
`timescale 1ns/10ps
module dmd_decode (
   input wire logic [13:0] instr_i,
   dmd_dec_if.dec dec
);
   always_comb begin
      dec.lit = instr_i[7:0];
      dec.addr = instr_i[6:0];
      dec.dest_reg = instr_i[dmd_pkg::DEST_BIT];
      dec.op = dmd_pkg::OP_NONE;
      if (instr_i[13:dmd_pkg::LIT_TOP_LSB] == dmd_pkg::LIT_TOP_VAL) begin
         dec.op = dmd_pkg::OP_LIT;
      end else if (instr_i[13:8] == dmd_pkg::COPY_TOP_VAL) begin
         dec.op = dmd_pkg::OP_COPY;
      end else if (instr_i[13:7] == dmd_pkg::STORE_TOP_VAL) begin
         dec.op = dmd_pkg::OP_STORE;
      end else if ((instr_i & dmd_pkg::IDLE_MASK) == dmd_pkg::IDLE_VAL) begin
         dec.op = dmd_pkg::OP_IDLE;
      end
   end
endmodule

// File: design/dmd_core.sv
// top: four-phase execution of the data-move instructions
// Operation
// - literal load 11 00xx kkkkkkkk puts k in accumulator, flags untouched.
// - copy 00 1000 d fffffff with d clear writes register value to accumulator.
// - copy with d set writes the read value back into the same register.
// - copy sets zero flag when moved value is zero, clears otherwise.
// - copy decodes Q1, reads Q2, passes data Q3, writes destination Q4.
// - store 00 0000 1 fffffff writes accumulator to register, flags untouched.
// - idle pattern changes no register, memory or flag.
// - idle is one word; decode in Q1, other phases do nothing.
`timescale 1ns/10ps
module dmd_core (
   input wire logic ref_clk_i,
   input wire logic rst_n_i,
   input wire logic [13:0] instr_i,
   input wire logic [7:0] rf_rdata_i,
   output logic [1:0] phase_o,
   output logic rf_re_o,
   output logic [6:0] rf_raddr_o,
   output logic rf_we_o,
   output logic [6:0] rf_waddr_o,
   output logic [7:0] rf_wdata_o,
   output logic [7:0] acc_o,
   output logic zero_o,
   output logic zero_we_o,
   output logic pc_inc_o,
   output logic known_o
);
   // ---------------------------------------------
   // state
   // ---------------------------------------------
   typedef struct packed {
      dmd_pkg::dmd_phase_type ph;
      dmd_pkg::dmd_op_type op;
      logic dest_reg;
      logic [7:0] lit;
      logic [6:0] addr;
      logic [7:0] data;
      logic [7:0] acc;
      logic zero;
      logic re;
      logic we;
      logic zwe;
      logic pc_inc;
   } dmd_state_type;
   dmd_state_type s_q;
   dmd_state_type s_d;

   // ---------------------------------------------
   // decode
   // ---------------------------------------------
   dmd_dec_if dif ();
   dmd_decode dmd_decode_i (
      .instr_i(instr_i),
      .dec(dif.dec)
   );

   // ---------------------------------------------
   // next state
   // ---------------------------------------------
   // instruction word must be stable during Q1; it is latched there so
   // the fetch logic may move on while the rest of the cycle runs
   always_comb begin
      s_d = s_q;
      s_d.re = 1'b0;
      s_d.we = 1'b0;
      s_d.zwe = 1'b0;
      s_d.pc_inc = 1'b0;
      unique case (s_q.ph)
         dmd_pkg::PH_Q1: begin
            s_d.ph = dmd_pkg::PH_Q2;
            s_d.op = dif.op;
            s_d.dest_reg = dif.dest_reg;
            s_d.lit = dif.lit;
            s_d.addr = dif.addr;
            s_d.re = (dif.op == dmd_pkg::OP_COPY);
         end
         dmd_pkg::PH_Q2: begin
            s_d.ph = dmd_pkg::PH_Q3;
            if (s_q.op == dmd_pkg::OP_COPY) begin
               s_d.data = rf_rdata_i;
            end else if (s_q.op == dmd_pkg::OP_LIT) begin
               s_d.data = s_q.lit;
            end else if (s_q.op == dmd_pkg::OP_STORE) begin
               s_d.data = s_q.acc;
            end
         end
         dmd_pkg::PH_Q3: begin
            s_d.ph = dmd_pkg::PH_Q4;
            // write strobe is raised for exactly the Q4 phase
            s_d.we = (s_q.op == dmd_pkg::OP_STORE) ||
                     (s_q.op == dmd_pkg::OP_COPY && s_q.dest_reg);
            s_d.zwe = (s_q.op == dmd_pkg::OP_COPY);
            s_d.pc_inc = (s_q.op != dmd_pkg::OP_NONE);
            if (s_q.op == dmd_pkg::OP_LIT ||
                (s_q.op == dmd_pkg::OP_COPY && !s_q.dest_reg)) begin
               s_d.acc = s_q.data;
            end
            if (s_q.op == dmd_pkg::OP_COPY) begin
               s_d.zero = (s_q.data == 8'h00);
            end
         end
         dmd_pkg::PH_Q4: begin
            s_d.ph = dmd_pkg::PH_Q1;
         end
      endcase
   end
   always_ff @(posedge ref_clk_i) begin
      if (!rst_n_i) begin
         s_q <= '0;
         s_q.ph <= dmd_pkg::PH_Q1;
         s_q.op <= dmd_pkg::OP_NONE;
         s_q.acc <= dmd_pkg::ACC_RST;
         s_q.zero <= dmd_pkg::ZERO_RST;
      end else begin
         s_q <= s_d;
      end
   end

   // ---------------------------------------------
   // outputs
   // ---------------------------------------------
   // unknown words still advance phases but touch nothing; the rest of
   // the core owns them
   assign phase_o = s_q.ph;
   assign rf_re_o = s_q.re;
   assign rf_raddr_o = s_q.addr;
   assign rf_we_o = s_q.we;
   assign rf_waddr_o = s_q.addr;
   assign rf_wdata_o = s_q.data;
   assign acc_o = s_q.acc;
   assign zero_o = s_q.zero;
   assign zero_we_o = s_q.zwe;
   assign pc_inc_o = s_q.pc_inc;
   assign known_o = (s_q.op != dmd_pkg::OP_NONE);

   // ---------------------------------------------
   // assertions
   // ---------------------------------------------
   default clocking cb @(posedge ref_clk_i); endclocking
   default disable iff (!rst_n_i);

   lit_load_acc_a: assert property (
      s_q.ph == dmd_pkg::PH_Q1 && dif.op == dmd_pkg::OP_LIT
      |-> ##3 acc_o == $past(instr_i[7:0], 3) && !zero_we_o && $stable(zero_o))
      else $error("literal not loaded");
   copy_to_acc_a: assert property (
      s_q.ph == dmd_pkg::PH_Q2 && s_q.op == dmd_pkg::OP_COPY && !s_q.dest_reg
      |-> ##2 acc_o == $past(rf_rdata_i, 2))
      else $error("copy to accumulator wrong");
   copy_back_a: assert property (
      s_q.ph == dmd_pkg::PH_Q2 && s_q.op == dmd_pkg::OP_COPY && s_q.dest_reg
      |-> ##2 rf_we_o && rf_wdata_o == $past(rf_rdata_i, 2) && $stable(acc_o))
      else $error("copy back wrong");
   zero_flag_a: assert property (
      s_q.ph == dmd_pkg::PH_Q2 && s_q.op == dmd_pkg::OP_COPY
      |-> ##2 zero_we_o && zero_o == ($past(rf_rdata_i, 2) == 8'h00))
      else $error("zero flag wrong");
   copy_phases_a: assert property (
      s_q.ph == dmd_pkg::PH_Q1 && dif.op == dmd_pkg::OP_COPY
      |=> rf_re_o ##1 !rf_re_o ##1 (rf_we_o == s_q.dest_reg))
      else $error("copy phase order wrong");
   store_reg_a: assert property (
      s_q.ph == dmd_pkg::PH_Q2 && s_q.op == dmd_pkg::OP_STORE
      |-> ##2 rf_we_o && rf_wdata_o == $past(acc_o, 2) && !zero_we_o)
      else $error("store wrong");
   idle_quiet_a: assert property (
      s_q.ph == dmd_pkg::PH_Q1 && dif.op == dmd_pkg::OP_IDLE
      |=> (!rf_we_o && !zero_we_o && $stable(acc_o) && $stable(zero_o)) [*3])
      else $error("idle changed state");
   idle_phase_a: assert property (
      s_q.ph == dmd_pkg::PH_Q2 && s_q.op == dmd_pkg::OP_IDLE
      |-> (!rf_re_o && !rf_we_o && !zero_we_o) [*3])
      else $error("idle read register");
   one_cycle_a: assert property (
      pc_inc_o |-> phase_o == dmd_pkg::PH_Q4 ##1 !pc_inc_o [*3])
      else $error("program counter step wrong");

   // datapath strobes only in their own phase
   read_pulse_a: assert property (
      rf_re_o |-> phase_o == dmd_pkg::PH_Q2 && s_q.op == dmd_pkg::OP_COPY)
      else $error("read strobe out of place");
   write_slot_a: assert property (
      rf_we_o |-> phase_o == dmd_pkg::PH_Q4 && (s_q.op == dmd_pkg::OP_STORE ||
      (s_q.op == dmd_pkg::OP_COPY && s_q.dest_reg)))
      else $error("write strobe out of place");
   zero_write_slot_a: assert property (
      zero_we_o |-> phase_o == dmd_pkg::PH_Q4 && s_q.op == dmd_pkg::OP_COPY)
      else $error("zero write out of place");
   addr_read_a: assert property (
      rf_re_o |-> rf_raddr_o == $past(instr_i[6:0]))
      else $error("read address wrong");
   addr_write_a: assert property (
      rf_we_o |-> rf_waddr_o == $past(instr_i[6:0], 3))
      else $error("write address wrong");

   // accumulator and flag move only with their write slot
   acc_hold_a: assert property (
      phase_o != dmd_pkg::PH_Q4 |-> $stable(acc_o))
      else $error("accumulator moved outside Q4");
   zero_hold_a: assert property (
      !zero_we_o |-> $stable(zero_o))
      else $error("zero flag moved without write");
   lit_no_write_a: assert property (
      s_q.ph == dmd_pkg::PH_Q2 && s_q.op == dmd_pkg::OP_LIT |-> ##2 !rf_we_o && pc_inc_o)
      else $error("literal touched register file");
   store_keeps_acc_a: assert property (
      s_q.ph == dmd_pkg::PH_Q2 && s_q.op == dmd_pkg::OP_STORE
      |-> ##2 $stable(acc_o) && $stable(zero_o) && pc_inc_o)
      else $error("store changed accumulator or flag");

   // cycle framing
   phase_ring_a: assert property (
      phase_o == dmd_pkg::PH_Q1 |=> phase_o == dmd_pkg::PH_Q2 ##1 phase_o == dmd_pkg::PH_Q3
      ##1 phase_o == dmd_pkg::PH_Q4 ##1 phase_o == dmd_pkg::PH_Q1)
      else $error("phase ring broken");
   known_pc_a: assert property (
      phase_o == dmd_pkg::PH_Q4 |-> pc_inc_o == known_o)
      else $error("step and known disagree");
   unknown_quiet_a: assert property (
      s_q.ph == dmd_pkg::PH_Q1 && dif.op == dmd_pkg::OP_NONE
      |=> (!rf_re_o && !rf_we_o && !zero_we_o && !pc_inc_o && $stable(acc_o)) [*3])
      else $error("unknown word did something");
   // the reset check opts out of the default disable so it sees the reset edge itself
   reset_values_a: assert property (disable iff (1'b0)
      !rst_n_i |=> phase_o == dmd_pkg::PH_Q1 && !rf_re_o && !rf_we_o && !zero_we_o
      && !pc_inc_o && acc_o == dmd_pkg::ACC_RST && zero_o == dmd_pkg::ZERO_RST)
      else $error("reset state wrong");

   // ---------------------------------------------
   // coverage
   // ---------------------------------------------
   lit_c: cover property (s_q.ph == dmd_pkg::PH_Q4 && s_q.op == dmd_pkg::OP_LIT);
   copy_c: cover property (rf_we_o && s_q.op == dmd_pkg::OP_COPY);
   zero_c: cover property (zero_we_o && zero_o);
   store_c: cover property (rf_we_o && s_q.op == dmd_pkg::OP_STORE);
   idle_c: cover property (pc_inc_o && s_q.op == dmd_pkg::OP_IDLE);
endmodule

// File: verif/dmd_core_test.sv
// testbench: self-checking run of the data-move decoder top
`timescale 1ns/10ps
module dmd_core_test;
   // ---------------------------------------------
   // stimulus, outputs and captured results
   // ---------------------------------------------
   logic ref_clk_i = 1'b0;
   logic rst_n_i = 1'b0;
   logic [13:0] instr_i = 14'h0000;
   logic [7:0] rf_rdata_i = 8'h00;
   logic [1:0] phase_o, ph_s;
   logic rf_re_o, rf_we_o, zero_o, zero_we_o, pc_inc_o, known_o;
   logic [6:0] rf_raddr_o, rf_waddr_o, ra_s, wa_s;
   logic [7:0] rf_wdata_o, acc_o, wd_s, acc_s;
   logic re_s, we_s, z_s, zwe_s, pci_s, kn_s;
   int failures = 0;
   int checks = 0;

   always #10 ref_clk_i = ~ref_clk_i;

   dmd_core dmd_core_i (.ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i), .instr_i(instr_i),
      .rf_rdata_i(rf_rdata_i), .phase_o(phase_o), .rf_re_o(rf_re_o),
      .rf_raddr_o(rf_raddr_o), .rf_we_o(rf_we_o), .rf_waddr_o(rf_waddr_o),
      .rf_wdata_o(rf_wdata_o), .acc_o(acc_o), .zero_o(zero_o), .zero_we_o(zero_we_o),
      .pc_inc_o(pc_inc_o), .known_o(known_o));

   // ---------------------------------------------
   // shared tasks
   // ---------------------------------------------
   task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
      checks++;
      if (seen !== exp) begin
         failures++;
         $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask

   task summarize;
      $display("checks=%0d failures=%0d", checks, failures);
      if (failures == 0 && checks > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask

   // one instruction cycle from Q1; word and read data are scrambled after
   // their sampling edges so a late sample shows up as wrong data
   task automatic exec(input logic [13:0] w, input logic [7:0] rd);
      instr_i = w;
      rf_rdata_i = rd;
      @(negedge ref_clk_i);
      re_s = rf_re_o;
      ra_s = rf_raddr_o;
      instr_i = ~w;
      @(negedge ref_clk_i);
      rf_rdata_i = ~rd;
      @(negedge ref_clk_i);
      {ph_s, we_s, wa_s, wd_s, acc_s} = {phase_o, rf_we_o, rf_waddr_o, rf_wdata_o, acc_o};
      {z_s, zwe_s, pci_s, kn_s} = {zero_o, zero_we_o, pc_inc_o, known_o};
      @(negedge ref_clk_i);
   endtask

   // ---------------------------------------------
   // scenarios
   // ---------------------------------------------
   task t_lit;
      exec(14'h335A, 8'h00);
      chk(acc_s, 8'h5A);
      chk({zwe_s, we_s}, 2'h0);
      chk({pci_s, kn_s}, 2'h3);
   endtask

   task t_copy_w;
      exec(14'h0823, 8'h00);
      chk({re_s, ra_s}, 8'hA3);
      chk(acc_s, 8'h00);
      chk({z_s, zwe_s, we_s}, 3'h6);
      chk(ph_s, 2'h3);
      exec(14'h0823, 8'h93);
      chk(acc_s, 8'h93);
      chk({z_s, zwe_s}, 2'h1);
   endtask

   task t_copy_f;
      exec(14'h08FF, 8'h00);
      chk({we_s, wa_s}, 8'hFF);
      chk(wd_s, 8'h00);
      chk(acc_s, 8'h93);
      chk({z_s, zwe_s, pci_s}, 3'h7);
   endtask

   task t_store;
      exec(14'h304F, 8'h00);
      exec(14'h00C5, 8'hAA);
      chk({we_s, wa_s}, 8'hC5);
      chk(wd_s, 8'h4F);
      chk({z_s, zwe_s}, 2'h2);
      chk(pci_s, 1'b1);
   endtask

   task t_idle;
      exec(14'h0060, 8'h00);
      chk({re_s, we_s, zwe_s}, 3'h0);
      chk({acc_s, z_s}, 9'h09F);
      chk({pci_s, kn_s}, 2'h3);
      // a word outside the four must not advance the program counter
      exec(14'h3800, 8'h00);
      chk({pci_s, kn_s, we_s}, 3'h0);
      chk(acc_s, 8'h4F);
   endtask

   // reset dropped mid-run with a copy word waiting; nothing may leak through
   task t_reset;
      instr_i = 14'h0823;
      rst_n_i = 1'b0;
      @(negedge ref_clk_i);
      @(negedge ref_clk_i);
      chk({phase_o, rf_re_o, rf_we_o, zero_we_o, pc_inc_o, known_o}, 7'h00);
      chk({acc_o, zero_o}, 9'h000);
      rst_n_i = 1'b1;
      exec(14'h3281, 8'h00);
      chk(acc_s, 8'h81);
      chk({ph_s, z_s, pci_s}, 4'hD);
   endtask

   // ---------------------------------------------
   // main sequence and watchdog
   // ---------------------------------------------
   initial begin
      repeat (3) @(posedge ref_clk_i);
      @(negedge ref_clk_i);
      rst_n_i = 1'b1;
      t_lit;
      t_copy_w;
      t_copy_f;
      t_store;
      t_idle;
      t_reset;
      summarize;
   end

   // whole run is nine instruction cycles plus reset, well under this span
   initial begin
      #20000;
      failures++;
      summarize;
   end
endmodule
